// ---- rtl/dfs_pkg.sv ----
// Purpose: Shared constants and state types of the driver fault-status logic.
// Assumes: 50 MHz core clock; 16-bit serial words, shifted least significant bit first.
// Notes: The pin group is held as one packed struct inside the top module; no port uses it.
package dfs_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int CHANNELS = 8;
    localparam int PAIRS = 4;
    localparam int PAR_INPUTS = 4;
    localparam int WORD_BITS = 16;
    localparam int CNT_W = 4;
    localparam int FILT_W = 16;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_MHZ = 50;
    localparam int FILTER_TIME_US = 100;
    localparam int FILTER_CYCLES = FILTER_TIME_US * CLK_MHZ;

    ////////////////////////////////////////////////////////////////////////////////
    // Input word fields
    localparam int IN_ON_LSB = 0;
    localparam int IN_OLEN_LSB = 8;
    // Parallel inputs steer channels five to eight
    localparam int PAR_CH_LSB = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // Output word fields
    localparam int OUT_TW_BIT = 0;
    localparam int OUT_CH_LSB = 1;
    localparam int OUT_PSF_BIT = 15;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [WORD_BITS-1:0] WORD_RST = 16'h0000;
    localparam logic [CHANNELS-1:0] CH_RST = 8'h00;
    localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
    localparam logic [FILT_W-1:0] FILT_RST = 16'h0000;
    localparam logic [FILT_W-1:0] FILT_ONE = 16'h0001;

    typedef struct packed {
        logic en;
        logic csn;
        logic sclk;
        logic sdi;
        logic [PAR_INPUTS-1:0] par;
        logic [CHANNELS-1:0] open_load;
        logic [CHANNELS-1:0] over_current;
        logic [PAIRS-1:0] thermal_warn;
        logic [PAIRS-1:0] thermal_shut;
        logic supply_fault;
    } dfs_pins_t;

    localparam dfs_pins_t PINS_RST = '{csn: 1'b1, default: '0};

    typedef struct packed {
        logic [FILT_W-1:0] cnt;
        logic hit;
    } dfs_filt_t;

endpackage

// ---- rtl/dfs_filter.sv ----
// Purpose: Persistence filter for one channel's over-current or open-load indication.
// Assumes: cond is already synchronised to mclk.
// Notes: hit rises once cond has held for LIMIT cycles and drops with cond.
`timescale 1ns/1ps
module dfs_filter #(
    parameter int LIMIT = dfs_pkg::FILTER_CYCLES
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic clr,
    input wire logic cond,
    output logic hit
);

    dfs_pkg::dfs_filt_t st_q;
    dfs_pkg::dfs_filt_t st_d;

    localparam logic [dfs_pkg::FILT_W-1:0] LIMIT_C = dfs_pkg::FILT_W'(LIMIT);

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d = st_q;
        if (clr || !cond) begin
            st_d.cnt = dfs_pkg::FILT_RST;
            st_d.hit = 1'b0;
        end else if (st_q.cnt + dfs_pkg::FILT_ONE >= LIMIT_C) begin
            // Saturate so a long fault never wraps back to clear
            st_d.cnt = LIMIT_C;
            st_d.hit = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + dfs_pkg::FILT_ONE;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '{cnt: dfs_pkg::FILT_RST, hit: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign hit = st_q.hit;

endmodule // dfs_filter

// ---- rtl/dfs_top.sv ----
// Purpose: Enable, serial frame handling and fault latching of an eight-channel driver.
// Assumes: All pins are asynchronous to mclk and pass two flip-flops first.
// Notes: Serial clock is oversampled; it must stay well below a quarter of mclk.
//
// Operation
// - Enable low resets logic, turns drivers off, clears registers, signals low power.
// - Enable high activates device; parallel inputs then drive channels five to eight.
// - Open load reported only when its diagnostic is enabled and condition present.
// - Open load is not latched and not reported while that driver is on.
// - Open load is captured into the shift word at chip select fall only.
// - Open-load check only when serial on bit and parallel input are both zero.
// - Over-current reported and driver latched off after lasting the filter time.
// - Valid frame with on bit zero clears over-current; next frame may turn on.
// - Thermal warning in output bit zero, following the sensor's hysteretic indication.
// - Thermal warning is sampled and presented only while chip select is low.
// - Thermal shutdown turns off both drivers of the pair and latches their status.
// - Shutdown latch clears when indication gone and valid frame holds bits zero.
// - Load-supply over or undervoltage latched into output bit fifteen.
// - All drivers forced off while the load-supply fault is present.
// - After supply fault ends drivers follow the last valid frame's command.
// - Any valid frame clears the latched supply-fault bit once the supply fault has gone.
// - Over-current and open load recognised only after persisting, one timer per channel.
// - Every latch also clears when enable is toggled low.
// - Chip select fall puts the thermal warning onto serial output at once.
// - Input bits eight to fifteen enable open-load diagnostics per channel.
`timescale 1ns/1ps
module dfs_top #(
    parameter int FILTER_CYCLES = dfs_pkg::FILTER_CYCLES
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic enable_pin,
    input wire logic chip_select_n,
    input wire logic sclk,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe_n,
    input wire logic [dfs_pkg::PAR_INPUTS-1:0] parallel_drive_inputs,
    input wire logic [dfs_pkg::CHANNELS-1:0] open_load_det,
    input wire logic [dfs_pkg::CHANNELS-1:0] over_current_det,
    input wire logic [dfs_pkg::PAIRS-1:0] thermal_warn_det,
    input wire logic [dfs_pkg::PAIRS-1:0] thermal_shut_det,
    input wire logic load_supply_fault,
    output logic [dfs_pkg::CHANNELS-1:0] driver_on,
    output logic low_power
);

    typedef struct packed {
        dfs_pkg::dfs_pins_t sync1;
        dfs_pkg::dfs_pins_t sync2;
        logic csn_prev;
        logic sclk_prev;
        logic si_bit;
        logic [dfs_pkg::WORD_BITS-1:0] tx_sr;
        logic [dfs_pkg::WORD_BITS-1:0] rx_sr;
        logic [dfs_pkg::CNT_W-1:0] bit_cnt;
        logic got_bits;
        logic shifted;
        logic [dfs_pkg::CHANNELS-1:0] on_cmd;
        logic [dfs_pkg::CHANNELS-1:0] ol_en;
        logic [dfs_pkg::CHANNELS-1:0] oc_lat;
        logic [dfs_pkg::CHANNELS-1:0] ts_lat;
        logic psf_lat;
        logic [dfs_pkg::CHANNELS-1:0] drv;
        logic sdo;
        logic sdo_oe_n;
        logic low_power;
    } dfs_state_t;

    localparam dfs_state_t STATE_RST = '{
        sync1: dfs_pkg::PINS_RST,
        sync2: dfs_pkg::PINS_RST,
        csn_prev: 1'b1,
        sclk_prev: 1'b0,
        si_bit: 1'b0,
        tx_sr: dfs_pkg::WORD_RST,
        rx_sr: dfs_pkg::WORD_RST,
        bit_cnt: dfs_pkg::CNT_RST,
        got_bits: 1'b0,
        shifted: 1'b0,
        on_cmd: dfs_pkg::CH_RST,
        ol_en: dfs_pkg::CH_RST,
        oc_lat: dfs_pkg::CH_RST,
        ts_lat: dfs_pkg::CH_RST,
        psf_lat: 1'b0,
        drv: dfs_pkg::CH_RST,
        sdo: 1'b0,
        sdo_oe_n: 1'b1,
        low_power: 1'b1
    };

    // Bit counter wraps at the word length, so whole words leave it at zero
    localparam logic [dfs_pkg::CNT_W-1:0] CNT_ONE = dfs_pkg::CNT_W'(1);

    dfs_state_t st_q;
    dfs_state_t st_d;
    dfs_pkg::dfs_pins_t pins;
    logic [dfs_pkg::CHANNELS-1:0] filt_cond;
    logic [dfs_pkg::CHANNELS-1:0] filt_hit;
    logic [dfs_pkg::CHANNELS-1:0] drv_chg;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Spread a per-pair flag onto both channels of the pair
    function automatic logic [dfs_pkg::CHANNELS-1:0] pair_to_ch(
        input logic [dfs_pkg::PAIRS-1:0] p
    );
        logic [dfs_pkg::CHANNELS-1:0] c;
        c = dfs_pkg::CH_RST;
        for (int i = 0; i < dfs_pkg::PAIRS; i++) begin
            c[2*i] = p[i];
            c[2*i+1] = p[i];
        end
        return c;
    endfunction

    // Place the parallel inputs on channels five to eight
    function automatic logic [dfs_pkg::CHANNELS-1:0] par_to_ch(
        input logic [dfs_pkg::PAR_INPUTS-1:0] p
    );
        logic [dfs_pkg::CHANNELS-1:0] c;
        c = dfs_pkg::CH_RST;
        c[dfs_pkg::PAR_CH_LSB +: dfs_pkg::PAR_INPUTS] = p;
        return c;
    endfunction

    // Rising edge of a synchronised level, against its value one cycle earlier
    function automatic logic went_high(
        input logic prev,
        input logic cur
    );
        return !prev && cur;
    endfunction

    // Falling counterpart of went_high
    function automatic logic went_low(
        input logic prev,
        input logic cur
    );
        return prev && !cur;
    endfunction

    // Status word as it is loaded at chip select fall; bits nine to fourteen stay zero
    function automatic logic [dfs_pkg::WORD_BITS-1:0] status_word(
        input logic warn,
        input logic [dfs_pkg::CHANNELS-1:0] ch_fault,
        input logic supply
    );
        logic [dfs_pkg::WORD_BITS-1:0] w;
        w = dfs_pkg::WORD_RST;
        w[dfs_pkg::OUT_TW_BIT] = warn;
        w[dfs_pkg::OUT_CH_LSB +: dfs_pkg::CHANNELS] = ch_fault;
        w[dfs_pkg::OUT_PSF_BIT] = supply;
        return w;
    endfunction

    // Drivers follow the command unless a latch, live shutdown or supply fault forbids
    function automatic logic [dfs_pkg::CHANNELS-1:0] drive_mask(
        input logic [dfs_pkg::CHANNELS-1:0] want,
        input logic [dfs_pkg::CHANNELS-1:0] blocked,
        input logic supply_bad
    );
        return want & ~blocked & {dfs_pkg::CHANNELS{!supply_bad}};
    endfunction

    // Over-current is watched while a driver is on, open load while it is off;
    // one timer can then serve both
    function automatic logic watch(
        input logic on,
        input logic oc,
        input logic ol,
        input logic ol_enabled
    );
        return on ? oc : (ol && ol_enabled);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Pin packing
    always_comb begin
        pins.en = enable_pin;
        pins.csn = chip_select_n;
        pins.sclk = sclk;
        pins.sdi = sdi;
        pins.par = parallel_drive_inputs;
        pins.open_load = open_load_det;
        pins.over_current = over_current_det;
        pins.thermal_warn = thermal_warn_det;
        pins.thermal_shut = thermal_shut_det;
        pins.supply_fault = load_supply_fault;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-channel filters
    // One timer per channel serves both faults: over-current only matters while the
    // driver is on and open load only while it is off, so they never compete.
    always_comb begin
        for (int i = 0; i < dfs_pkg::CHANNELS; i++) begin
            filt_cond[i] = watch(st_q.drv[i], st_q.sync2.over_current[i],
                                 st_q.sync2.open_load[i], st_q.ol_en[i]);
        end
    end

    // A driver that switches hands its timer to the other fault, so the count restarts;
    // otherwise an open-load hit still held at turn-on would latch a false over-current
    // in the very next cycle.
    assign drv_chg = st_d.drv ^ st_q.drv;

    for (genvar g = 0; g < dfs_pkg::CHANNELS; g++) begin : g_filt
        dfs_filter #(
            .LIMIT(FILTER_CYCLES)
        ) u_filt (
            .mclk(mclk),
            .arst_n(arst_n),
            .clr(!st_q.sync2.en || drv_chg[g]),
            .cond(filt_cond[g]),
            .hit(filt_hit[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic en;
        logic cs_fall;
        logic cs_rise;
        logic sclk_rise;
        logic sclk_fall;
        logic frame_ok;
        logic tw_now;
        logic vs_bad;
        logic [dfs_pkg::CHANNELS-1:0] new_on;
        logic [dfs_pkg::CHANNELS-1:0] cmd;
        logic [dfs_pkg::CHANNELS-1:0] ts_now;
        logic [dfs_pkg::CHANNELS-1:0] ol_now;
        logic [dfs_pkg::CHANNELS-1:0] oc_set;
        logic [dfs_pkg::WORD_BITS-1:0] status;

        st_d = st_q;
        st_d.sync1 = pins;
        st_d.sync2 = st_q.sync1;
        st_d.csn_prev = st_q.sync2.csn;
        st_d.sclk_prev = st_q.sync2.sclk;

        en = st_q.sync2.en;
        cs_fall = went_low(st_q.csn_prev, st_q.sync2.csn);
        cs_rise = went_high(st_q.csn_prev, st_q.sync2.csn);
        sclk_rise = went_high(st_q.sclk_prev, st_q.sync2.sclk) && !st_q.sync2.csn;
        sclk_fall = went_low(st_q.sclk_prev, st_q.sync2.sclk) && !st_q.sync2.csn;
        frame_ok = cs_rise && st_q.got_bits && (st_q.bit_cnt == dfs_pkg::CNT_RST);
        new_on = st_q.rx_sr[dfs_pkg::IN_ON_LSB +: dfs_pkg::CHANNELS];
        tw_now = |st_q.sync2.thermal_warn;
        vs_bad = st_q.sync2.supply_fault;
        ts_now = pair_to_ch(st_q.sync2.thermal_shut);
        cmd = st_q.on_cmd | par_to_ch(st_q.sync2.par);

        // Open load: not latched, only for channels commanded off both ways
        ol_now = filt_hit & st_q.ol_en & ~cmd & ~st_q.drv & {dfs_pkg::CHANNELS{!vs_bad}};
        oc_set = filt_hit & st_q.drv;

        status = status_word(
            tw_now,
            st_q.oc_lat | st_q.ts_lat | ol_now,
            st_q.psf_lat
        );

        // Bits are taken on the synchronised rising serial edge and shifted out on the
        // falling one, some three core cycles after the pins; hence the speed limit.
        if (cs_fall) begin
            st_d.tx_sr = status;
            st_d.bit_cnt = dfs_pkg::CNT_RST;
            st_d.got_bits = 1'b0;
            st_d.shifted = 1'b0;
        end else if (!st_q.sync2.csn && !st_q.shifted) begin
            // Warning bit keeps tracking until the first bit leaves
            st_d.tx_sr[dfs_pkg::OUT_TW_BIT] = tw_now;
        end
        if (sclk_rise) begin
            st_d.si_bit = st_q.sync2.sdi;
            st_d.rx_sr = {st_q.sync2.sdi, st_q.rx_sr[dfs_pkg::WORD_BITS-1:1]};
            st_d.bit_cnt = st_q.bit_cnt + CNT_ONE;
            st_d.got_bits = 1'b1;
        end
        if (sclk_fall) begin
            // Received bits ride through the output register for daisy chaining
            st_d.tx_sr = {st_q.si_bit, st_q.tx_sr[dfs_pkg::WORD_BITS-1:1]};
            st_d.shifted = 1'b1;
        end

        // Frame commit and clearing of latches
        // A frame of the wrong length leaves commands and latches untouched
        if (frame_ok) begin
            st_d.on_cmd = new_on;
            st_d.ol_en = st_q.rx_sr[dfs_pkg::IN_OLEN_LSB +: dfs_pkg::CHANNELS];
            st_d.oc_lat = st_q.oc_lat & new_on;
            st_d.ts_lat = st_q.ts_lat & (new_on | ts_now);
            st_d.psf_lat = 1'b0;
        end

        // Setting wins over a clear in the same cycle
        st_d.oc_lat = st_d.oc_lat | oc_set;
        st_d.ts_lat = st_d.ts_lat | ts_now;
        st_d.psf_lat = st_d.psf_lat | vs_bad;

        // Drivers: command masked by latches, live shutdown and supply state.
        // The stored command survives a supply fault, so drivers come back by themselves.
        cmd = st_d.on_cmd | par_to_ch(st_q.sync2.par);
        st_d.drv = drive_mask(cmd, st_d.oc_lat | st_d.ts_lat | ts_now,
                              vs_bad);

        st_d.sdo = st_d.tx_sr[0];
        st_d.sdo_oe_n = st_q.sync2.csn;
        st_d.low_power = 1'b0;

        // Enable low acts as a logic reset; the pin chain keeps sampling
        // Every latch goes with it, so toggling enable clears all faults
        if (!en) begin
            st_d = STATE_RST;
            st_d.sync1 = pins;
            st_d.sync2 = st_q.sync1;
            st_d.csn_prev = st_q.sync2.csn;
            st_d.sclk_prev = st_q.sync2.sclk;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= STATE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs
    // Every output comes straight from a flip-flop
    assign sdo = st_q.sdo;
    assign sdo_oe_n = st_q.sdo_oe_n;
    assign driver_on = st_q.drv;
    assign low_power = st_q.low_power;

endmodule // dfs_top

// ---- test/dfs_chk.sv ----
// Purpose: Port-level checks of the driver fault-status block.
// Assumes: Pins pass two sync flops; FILTER_CYCLES matches the instance.
// Notes: Bounds allow a few cycles of sync and register delay.
`timescale 1ns/1ps
module dfs_chk #(
    parameter int FILTER_CYCLES = dfs_pkg::FILTER_CYCLES
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic enable_pin,
    input wire logic chip_select_n,
    input wire logic [dfs_pkg::CHANNELS-1:0] over_current_det,
    input wire logic [dfs_pkg::PAIRS-1:0] thermal_warn_det,
    input wire logic [dfs_pkg::PAIRS-1:0] thermal_shut_det,
    input wire logic load_supply_fault,
    input wire logic sdo,
    input wire logic sdo_oe_n,
    input wire logic [dfs_pkg::CHANNELS-1:0] driver_on,
    input wire logic low_power
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////
    // Counts how long channel two stays on into an over-current
    int oc_q;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            oc_q <= 0;
        end else if (over_current_det[1] && driver_on[1]) begin
            oc_q <= oc_q + 1;
        end else begin
            oc_q <= 0;
        end
    end
    chk_enable_off: assert property (!enable_pin [*3] |=> driver_on == 8'h00 && low_power)
        else $error("drivers or low power wrong while disabled");
    chk_enable_wake: assert property (enable_pin [*4] |=> !low_power)
        else $error("low power stays after enable");
    chk_supply_off: assert property (load_supply_fault [*3] |=> driver_on == 8'h00)
        else $error("driver on during supply fault");
    chk_pair_shut: assert property (thermal_shut_det[1] [*3] |=> driver_on[3:2] == 2'b00)
        else $error("pair driver on during shutdown");
    chk_oc_latch: assert property (oc_q <= FILTER_CYCLES + 6)
        else $error("over-current driver not latched off");
    chk_oe_select: assert property ((enable_pin && !chip_select_n) [*4] |=> !sdo_oe_n)
        else $error("sdo not enabled while selected");
    chk_oe_idle: assert property (chip_select_n [*3] |=> sdo_oe_n)
        else $error("sdo enabled while not selected");
    chk_warn_first: assert property ($stable(thermal_warn_det) [*4] ##0 $fell(sdo_oe_n)
        |-> sdo == (|thermal_warn_det)) else $error("first sdo bit not warning");
    chk_sdo_hold: assert property (sdo_oe_n && $past(sdo_oe_n) && !low_power
        && !$past(low_power) |-> $stable(sdo)) else $error("sdo moved while deselected");
endmodule // dfs_chk
bind dfs_top dfs_chk #(.FILTER_CYCLES(FILTER_CYCLES)) u_chk (.mclk, .arst_n, .enable_pin,
    .chip_select_n, .over_current_det, .thermal_warn_det, .thermal_shut_det,
    .load_supply_fault, .sdo, .sdo_oe_n, .driver_on, .low_power);

// ---- test/dfs_host.sv ----
// Purpose: Host model acting as SPI master, mode 0, least significant bit first.
// Assumes: Half period of the serial clock is four mclk cycles.
// Notes: sdo is read late in each bit so the slow oversampled output has settled.
`timescale 1ns/1ps
module dfs_host (
    input wire logic mclk,
    output logic csn,
    output logic sclk,
    output logic sdi,
    input wire logic sdo
);
    initial begin
        csn = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    ////////////////////////////////////////
    // Caller picks the length; short ones exercise frame rejection
    task automatic xfer(input logic [15:0] w, input int nb, output logic [15:0] r);
        r = 16'h0000;
        @(posedge mclk) csn <= 1'b0;
        repeat (8) @(posedge mclk);
        for (int i = 0; i < nb; i++) begin
            sdi <= w[i % 16];
            repeat (4) @(posedge mclk);
            sclk <= 1'b1;
            repeat (4) @(posedge mclk);
            r[i % 16] = sdo;
            sclk <= 1'b0;
        end
        repeat (8) @(posedge mclk);
        csn <= 1'b1;
        // Pulled down when released
        sdi <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask
endmodule // dfs_host

// ---- test/dfs_top_tb.sv ----
// Purpose: Self-checking bench of the driver fault-status block.
// Assumes: Small filter count; host model drives the serial link.
// Notes: Random part keeps all faults but the thermal warning off so status words are predictable.
`timescale 1ns/1ps
module dfs_top_tb;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic en = 1'b0;
    logic [3:0] par = 4'h0;
    logic [7:0] ol = 8'h00;
    logic [7:0] oc = 8'h00;
    logic [3:0] tw = 4'h0;
    logic [3:0] ts = 4'h0;
    logic psf = 1'b0;
    logic csn, sclk, sdi, sdo, sdo_oe_n, lp;
    logic [7:0] drv;
    logic [15:0] r;
    logic [31:0] rnd = 32'h40ce;
    int mismatches = 0;
    int n_checks = 0;
    always #10 mclk = ~mclk;
    dfs_top #(.FILTER_CYCLES(8)) uut (.mclk(mclk), .arst_n(arst_n), .enable_pin(en),
        .chip_select_n(csn), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
        .parallel_drive_inputs(par), .open_load_det(ol), .over_current_det(oc),
        .thermal_warn_det(tw), .thermal_shut_det(ts), .load_supply_fault(psf),
        .driver_on(drv), .low_power(lp));
    dfs_host u_host (.mclk(mclk), .csn(csn), .sclk(sclk), .sdi(sdi), .sdo(sdo));
    ////////////////////////////////////////
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Either path may switch channels five to eight on
    function automatic logic [15:0] exp_drv(logic [7:0] on, logic [3:0] p);
        return {8'h00, on[7:4] | p, on[3:0]};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic fr(input logic [15:0] w, input logic [15:0] e);
        u_host.xfer(w, 16, r);
        chk(r, e);
    endtask
    task automatic dchk(input logic [15:0] e);
        @(negedge mclk);
        chk({7'h00, lp, drv}, e);
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        cyc(20);
        arst_n <= 1'b1;
        cyc(2);
        dchk(16'h0100);
        @(posedge mclk) en <= 1'b1;
        cyc(8);
        dchk(16'h0000);
        $display("test enable done");
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            @(posedge mclk) par <= rnd[3:0];
            tw <= rnd[7:4];
            cyc(4);
            fr({8'h00, rnd[15:8]}, {15'h0000, |rnd[7:4]});
            dchk(exp_drv(rnd[15:8], rnd[3:0]));
        end
        @(posedge mclk) par <= 4'h0;
        tw <= 4'h0;
        $display("test random done");
        ol <= 8'h05;
        u_host.xfer(16'hff00, 16, r);
        cyc(20);
        fr(16'hff01, 16'h000a);
        fr(16'h0000, 16'h0008);
        fr(16'h0000, 16'h0000);
        ol <= 8'h00;
        $display("test open load done");
        u_host.xfer(16'h0002, 16, r);
        @(posedge mclk) oc <= 8'h02;
        cyc(4);
        dchk(16'h0002);
        cyc(30);
        dchk(16'h0000);
        @(posedge mclk) oc <= 8'h00;
        u_host.xfer(16'h0000, 8, r);
        fr(16'h0002, 16'h0004);
        dchk(16'h0000);
        fr(16'h0000, 16'h0004);
        fr(16'h0002, 16'h0000);
        dchk(16'h0002);
        $display("test over-current done");
        u_host.xfer(16'h000c, 16, r);
        @(posedge mclk) ts <= 4'h2;
        cyc(6);
        dchk(16'h0000);
        u_host.xfer(16'h0000, 16, r);
        @(posedge mclk) ts <= 4'h0;
        cyc(4);
        fr(16'h000c, 16'h0018);
        dchk(16'h0000);
        fr(16'h0000, 16'h0018);
        fr(16'h000c, 16'h0000);
        dchk(16'h000c);
        $display("test shutdown done");
        u_host.xfer(16'h00a5, 16, r);
        @(posedge mclk) psf <= 1'b1;
        cyc(6);
        dchk(16'h0000);
        @(posedge mclk) psf <= 1'b0;
        cyc(6);
        dchk(16'h00a5);
        fr(16'h00a5, 16'h8000);
        fr(16'h00a5, 16'h0000);
        $display("test supply done");
        @(posedge mclk) psf <= 1'b1;
        cyc(6);
        @(posedge mclk) psf <= 1'b0;
        en <= 1'b0;
        cyc(6);
        dchk(16'h0100);
        @(posedge mclk) en <= 1'b1;
        cyc(8);
        fr(16'h0000, 16'h0000);
        $display("test enable clear done");
        tally_and_finish();
    end
endmodule // dfs_top_tb
